// ### verilog/splfc_pkg.sv
// package: register map, field codes and timing constants of the serial port
package splfc_pkg;

   // register byte addresses
   localparam logic [4:0]  A_CTRL   = 5'h00;
   localparam logic [4:0]  A_RATE   = 5'h04;
   localparam logic [4:0]  A_CHAN   = 5'h08;
   localparam logic [4:0]  A_ASYNC  = 5'h0c;
   localparam logic [4:0]  A_LEADS  = 5'h10;
   localparam logic [4:0]  A_STAT   = 5'h14;
   localparam logic [4:0]  A_MAP    = 5'h18;
   localparam logic [4:0]  A_CHAR   = 5'h1c;

   // control register bits
   localparam int          CTRL_W    = 10;
   localparam int          C_DTE     = 0;
   localparam int          C_CES     = 1;
   localparam int          C_ASYNC   = 2;
   localparam int          C_EXT     = 3;
   localparam int          C_INV     = 4;
   localparam int          C_DTRALM  = 5;
   localparam int          C_PORTEN  = 6;
   localparam int          C_RTSFRC  = 7;
   localparam int          C_CTSLONG = 8;
   localparam int          C_E1      = 9;
   localparam logic [9:0]  CTRL_RST  = 10'h040;

   // rate field, kbit/s
   localparam logic [11:0] RATE_RST = 12'h800;
   localparam logic [11:0] RATE_MIN = 12'h040;
   localparam logic [11:0] RATE_MAX = 12'h900;
   localparam int          CH_KBPS  = 64;

   // channel register fields and limits
   localparam int          CH_BUND_LSB  = 0;
   localparam int          CH_START_LSB = 4;
   localparam int          CH_COUNT_LSB = 16;
   localparam logic [1:0]  BUND_CONTIG  = 2'h0;
   localparam logic [1:0]  BUND_ALT     = 2'h1;
   localparam logic [1:0]  BUND_ARB     = 2'h2;
   localparam logic [4:0]  START_RST    = 5'h01;
   localparam logic [5:0]  COUNT_RST    = 6'h00;
   localparam logic [11:0] ST_T1_MIN    = 12'h001;
   localparam logic [11:0] ST_T1_MAX    = 12'h018;
   localparam logic [11:0] ST_E1_MIN    = 12'h000;
   localparam logic [11:0] ST_E1_MAX    = 12'h01f;
   localparam logic [11:0] CN_MIN       = 12'h000;
   localparam logic [11:0] CN_T1_MAX    = 12'h018;
   localparam logic [11:0] CN_E1_MAX    = 12'h020;
   localparam int          LINE_T1      = 25;
   localparam int          LINE_E1      = 32;

   // async register fields and codes
   localparam int          AS_FLOW_LSB = 0;
   localparam int          AS_SIZE_LSB = 2;
   localparam int          AS_PAR_LSB  = 4;
   localparam int          AS_STOP     = 6;
   localparam logic [6:0]  ASYNC_RST   = 7'h0c;
   localparam logic [1:0]  FLOW_NONE   = 2'h0;
   localparam logic [1:0]  FLOW_XON    = 2'h1;
   localparam logic [1:0]  FLOW_RTS    = 2'h2;
   localparam logic [1:0]  PAR_NONE    = 2'h0;
   localparam logic [1:0]  PAR_ODD     = 2'h1;
   localparam logic [1:0]  SIZE_MAX    = 2'h3;
   localparam logic [2:0]  DATA_LAST0  = 3'h4;
   localparam logic [7:0]  CHR_XON     = 8'h11;
   localparam logic [7:0]  CHR_XOFF    = 8'h13;

   // lead register fields and modes
   localparam int          LD_CTS_LSB = 0;
   localparam int          LD_DCD_LSB = 2;
   localparam int          LD_DSR_LSB = 4;
   localparam logic [5:0]  LEADS_RST  = 6'h00;
   localparam logic [1:0]  LEAD_TRUE  = 2'h0;
   localparam logic [1:0]  LEAD_FALSE = 2'h1;
   localparam logic [1:0]  LEAD_INT   = 2'h2;

   // status and character register bits
   localparam int          S_DTR  = 0;
   localparam int          S_DSR  = 1;
   localparam int          S_RTS  = 2;
   localparam int          S_CTS  = 3;
   localparam int          S_DCD  = 4;
   localparam int          S_DTE  = 5;
   localparam int          S_ALM  = 6;
   localparam int          S_EXT  = 7;
   localparam int          S_HOLD = 8;
   localparam int          R_PERR = 8;
   localparam int          R_FERR = 9;

   // timing
   localparam int          CLK_KHZ     = 125000;
   localparam logic [17:0] NCO_MOD     = 18'(CLK_KHZ);
   localparam int          CTS_NORM_MS = 30;
   localparam int          CTS_LONG_MS = 100;

   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} splfc_rx_t;

endpackage

// ### verilog/splfc_top.sv
// serial port lead control, clocking, channel map and async framing
// Function
// - port is DCE after reset; DTE role selectable by configuration
// - circuit emulation service forces DCE role
// - packet rate 64 to 2304 kbit/s, default 2048, ignored under CES
// - bundling contiguous or alternate channels, default contiguous
// - irregular allocation reads back arbitrary; arbitrary write refused
// - channels assigned from start channel; T1 1-24, E1 0-31, default 1
// - channel count T1 0-24, E1 0-32, default zero
// - bundling, start and count apply only under CES
// - sync or async format, sync by default
// - internal clock samples with driven clock; external with DTE clock
// - external clock only in packet mode; CES uses internal clock
// - invert option, default off, swaps the sampling edge
// - enabled DTR alarm raised while DTR low; status readable
// - async flow control none, Xon/Xoff or RTS/CTS, default none
// - async character of 5 to 8 data bits, default eight
// - parity none, odd or even; one or two stop bits
// - RTS taken from lead or forced true
// - CTS forced true, forced false, or follows RTS after delay
// - CTS delay about 30 ms normal or 100 ms long
// - DCD forced true, forced false, or follows network carrier
// - DSR forced true, forced false, or follows port enable
// - DTR, DSR, RTS, CTS, DCD and role readable live
`timescale 1ns/1ns
`default_nettype none

module splfc_top
   import splfc_pkg::*;
#(
   parameter logic [23:0] CtsNormCyc = 24'(CTS_NORM_MS * CLK_KHZ),
   parameter logic [23:0] CtsLongCyc = 24'(CTS_LONG_MS * CLK_KHZ)
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   output logic             txClkOut,
   input  wire logic        extClkIn,
   input  wire logic        txDataIn,
   input  wire logic        dtrIn,
   input  wire logic        rtsIn,
   input  wire logic        carrierIn,
   output logic             ctsOut,
   output logic             dcdOut,
   output logic             dsrOut,
   output logic             dtrAlarm,
   output logic             bitData,
   output logic             bitStb,
   output logic      [7:0]  charData,
   output logic             charStb,
   output logic             flowHold
);

   function automatic logic inRange(input logic [11:0] v,
                                    input logic [11:0] lo,
                                    input logic [11:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   function automatic logic leadSel(input logic [1:0] mode,
                                    input logic       intVal);
      logic r;
      r = 1'b1;
      if (mode == LEAD_FALSE) r = 1'b0;
      else if (mode == LEAD_INT) r = intVal;
      return r;
   endfunction

   // returns {truncated, channel mask}; mask bit n is channel n
   function automatic logic [32:0] chanMap(input logic [4:0] st,
                                           input logic [5:0] n,
                                           input logic       alt,
                                           input logic       e1);
      logic [31:0] m;
      logic        tr;
      int          c;
      int          top;
      m   = '0;
      tr  = 1'b0;
      c   = int'(st);
      top = e1 ? LINE_E1 : LINE_T1;
      for (int i = 0; i < LINE_E1; i++) begin
         if (i < int'(n)) begin
            if (c < top) m[c] = 1'b1;
            else tr = 1'b1;
            c = c + (alt ? 2 : 1);
         end
      end
      return {tr, m};
   endfunction

   logic [CTRL_W-1:0] ctrl_q;
   logic [11:0]       rate_q;
   logic [1:0]        bund_q;
   logic [4:0]        start_q;
   logic [5:0]        count_q;
   logic [6:0]        async_q;
   logic [5:0]        leads_q;
   logic [31:0]       map_q;
   logic              trunc_q;
   logic [31:0]       regRdata_q;
   logic [31:0]       rdMux;
   logic              extS1_q, extS2_q, extS3_q;
   logic              txdS1_q, txdS2_q;
   logic              dtrS1_q, dtrS2_q;
   logic              rtsS1_q, rtsS2_q;
   logic [17:0]       ncoAcc_q;
   logic [17:0]       ncoSum;
   logic              ncoTick;
   logic [11:0]       effRate;
   logic              txClk_q;
   logic              useExt;
   logic              sampleEv;
   logic              rtsEff;
   logic              rtsSeen_q;
   logic [23:0]       ctsCnt_q;
   logic [23:0]       ctsDly;
   logic              ctsInt_q;
   logic              ctsOut_q, dcdOut_q, dsrOut_q;
   logic              dtrAlarm_q, roleDte_q;
   logic              bitData_q, bitStb_q;
   splfc_rx_t         rxSt_q;
   logic [2:0]        rxCnt_q;
   logic [7:0]        rxSh_q;
   logic              rxPar_q, perr_q, ferr_q;
   logic [7:0]        charData_q;
   logic              charStb_q;
   logic              xoff_q, flowHold_q;
   logic [1:0]        asFlow, asSize, asPar;
   logic [32:0]       mapCalc;

   assign asFlow = async_q[AS_FLOW_LSB +: 2];
   assign asSize = async_q[AS_SIZE_LSB +: 2];
   assign asPar  = async_q[AS_PAR_LSB +: 2];

   // register writes; out-of-range values leave the field unchanged
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_q  <= CTRL_RST;
         rate_q  <= RATE_RST;
         bund_q  <= BUND_CONTIG;
         start_q <= START_RST;
         count_q <= COUNT_RST;
         async_q <= ASYNC_RST;
         leads_q <= LEADS_RST;
      end else if (regWr) begin
         case (regAddr)
            A_CTRL:  ctrl_q <= regWdata[CTRL_W-1:0];
            A_RATE:  if (inRange(regWdata[11:0], RATE_MIN, RATE_MAX)) begin
               rate_q <= regWdata[11:0];
            end
            A_CHAN: begin
               if (regWdata[CH_BUND_LSB +: 2] != BUND_ARB) begin
                  bund_q <= regWdata[CH_BUND_LSB +: 2];
               end
               if (inRange({7'h00, regWdata[CH_START_LSB +: 5]},
                           ctrl_q[C_E1] ? ST_E1_MIN : ST_T1_MIN,
                           ctrl_q[C_E1] ? ST_E1_MAX : ST_T1_MAX)) begin
                  start_q <= regWdata[CH_START_LSB +: 5];
               end
               if (inRange({6'h00, regWdata[CH_COUNT_LSB +: 6]}, CN_MIN,
                           ctrl_q[C_E1] ? CN_E1_MAX : CN_T1_MAX)) begin
                  count_q <= regWdata[CH_COUNT_LSB +: 6];
               end
            end
            A_ASYNC: async_q <= regWdata[6:0];
            A_LEADS: leads_q <= regWdata[5:0];
            default: ;
         endcase
      end
   end

   // channel map, live only under circuit emulation
   assign mapCalc = chanMap(start_q, count_q, bund_q == BUND_ALT,
                            ctrl_q[C_E1]);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         map_q   <= '0;
         trunc_q <= 1'b0;
      end else begin
         map_q   <= ctrl_q[C_CES] ? mapCalc[31:0] : '0;
         trunc_q <= ctrl_q[C_CES] & mapCalc[32];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) roleDte_q <= 1'b0;
      else roleDte_q <= ctrl_q[C_DTE] & ~ctrl_q[C_CES];
   end

   // two-flop synchronisers for the data, DTR and RTS pins; three flops for the external clock
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {extS1_q, extS2_q, extS3_q} <= 3'h0;
         {txdS1_q, txdS2_q}          <= 2'h3;
         {dtrS1_q, dtrS2_q}          <= 2'h0;
         {rtsS1_q, rtsS2_q}          <= 2'h0;
      end else begin
         extS1_q <= extClkIn;
         extS2_q <= extS1_q;
         extS3_q <= extS2_q;
         txdS1_q <= txDataIn;
         txdS2_q <= txdS1_q;
         dtrS1_q <= dtrIn;
         dtrS2_q <= dtrS1_q;
         rtsS1_q <= rtsIn;
         rtsS2_q <= rtsS1_q;
      end
   end

   // internal transmit clock: rate accumulator toggles at twice the bit rate
   always_comb begin
      effRate = ctrl_q[C_CES] ? 12'(count_q * CH_KBPS) : rate_q;
      ncoSum  = ncoAcc_q + {5'h00, effRate, 1'b0};
      ncoTick = ctrl_q[C_PORTEN] && (ncoSum >= NCO_MOD);
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ncoAcc_q <= '0;
         txClk_q  <= 1'b0;
      end else if (!ctrl_q[C_PORTEN]) begin
         ncoAcc_q <= '0;
         txClk_q  <= 1'b0;
      end else begin
         ncoAcc_q <= ncoTick ? ncoSum - NCO_MOD : ncoSum;
         txClk_q  <= txClk_q ^ ncoTick;
      end
   end

   assign useExt = ctrl_q[C_EXT] & ~ctrl_q[C_CES];

   // sampling edge of DTE data: clock source and polarity
   always_comb begin
      if (useExt) begin
         sampleEv = ctrl_q[C_INV] ? (extS3_q & ~extS2_q)
                                  : (extS2_q & ~extS3_q);
      end else begin
         sampleEv = ctrl_q[C_INV] ? (ncoTick & txClk_q)
                                  : (ncoTick & ~txClk_q);
      end
      sampleEv = sampleEv & ctrl_q[C_PORTEN];
   end

   // synchronous format: each sampled bit goes out with a strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bitData_q <= 1'b0;
         bitStb_q  <= 1'b0;
      end else begin
         bitStb_q <= sampleEv & ~ctrl_q[C_ASYNC];
         if (sampleEv) bitData_q <= txdS2_q;
      end
   end

   // asynchronous character framing, one sample per bit
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rxSt_q     <= RX_IDLE;
         rxCnt_q    <= '0;
         rxSh_q     <= '0;
         rxPar_q    <= 1'b0;
         perr_q     <= 1'b0;
         ferr_q     <= 1'b0;
         charData_q <= '0;
         charStb_q  <= 1'b0;
      end else begin
         charStb_q <= 1'b0;
         if (!ctrl_q[C_ASYNC]) begin
            rxSt_q <= RX_IDLE;
         end else if (sampleEv) begin
            unique case (rxSt_q)
               RX_IDLE: if (!txdS2_q) begin
                  rxSt_q  <= RX_DATA;
                  rxCnt_q <= '0;
                  rxPar_q <= 1'b0;
               end
               RX_DATA: begin
                  rxSh_q  <= {txdS2_q, rxSh_q[7:1]};
                  rxPar_q <= rxPar_q ^ txdS2_q;
                  rxCnt_q <= rxCnt_q + 3'h1;
                  if (rxCnt_q == DATA_LAST0 + {1'b0, asSize}) begin
                     rxSt_q  <= (asPar == PAR_NONE) ? RX_STOP : RX_PAR;
                     rxCnt_q <= '0;
                  end
               end
               RX_PAR: begin
                  perr_q <= rxPar_q ^ txdS2_q ^ (asPar == PAR_ODD);
                  rxSt_q <= RX_STOP;
               end
               RX_STOP: begin
                  if (async_q[AS_STOP] && rxCnt_q == '0) begin
                     rxCnt_q <= 3'h1;
                     ferr_q  <= ~txdS2_q;
                  end else begin
                     rxSt_q     <= RX_IDLE;
                     charStb_q  <= 1'b1;
                     charData_q <= rxSh_q >> (SIZE_MAX - asSize);
                     if (!async_q[AS_STOP]) ferr_q <= ~txdS2_q;
                     else ferr_q <= ferr_q | ~txdS2_q;
                     if (asPar == PAR_NONE) perr_q <= 1'b0;
                  end
               end
            endcase
         end
      end
   end

   // flow control toward the line side
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xoff_q     <= 1'b0;
         flowHold_q <= 1'b0;
      end else begin
         if (asFlow != FLOW_XON) xoff_q <= 1'b0;
         else if (charStb_q && charData_q == CHR_XOFF) xoff_q <= 1'b1;
         else if (charStb_q && charData_q == CHR_XON) xoff_q <= 1'b0;
         flowHold_q <= ctrl_q[C_ASYNC] &&
                       ((asFlow == FLOW_XON && xoff_q) ||
                        (asFlow == FLOW_RTS && !ctsOut_q));
      end
   end

   assign rtsEff = ctrl_q[C_RTSFRC] | rtsS2_q;
   assign ctsDly = ctrl_q[C_CTSLONG] ? CtsLongCyc : CtsNormCyc;

   // RTS must be stable for the whole delay before CTS follows it
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rtsSeen_q <= 1'b0;
         ctsCnt_q  <= '0;
         ctsInt_q  <= 1'b0;
      end else if (rtsEff != rtsSeen_q) begin
         rtsSeen_q <= rtsEff;
         ctsCnt_q  <= '0;
      end else if (ctsCnt_q < ctsDly) begin
         ctsCnt_q <= ctsCnt_q + 24'h1;
      end else begin
         ctsInt_q <= rtsSeen_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctsOut_q   <= 1'b1;
         dcdOut_q   <= 1'b1;
         dsrOut_q   <= 1'b1;
         dtrAlarm_q <= 1'b0;
      end else begin
         ctsOut_q   <= leadSel(leads_q[LD_CTS_LSB +: 2], ctsInt_q);
         dcdOut_q   <= leadSel(leads_q[LD_DCD_LSB +: 2], carrierIn);
         dsrOut_q   <= leadSel(leads_q[LD_DSR_LSB +: 2],
                               ctrl_q[C_PORTEN]);
         dtrAlarm_q <= ctrl_q[C_DTRALM] & ~dtrS2_q;
      end
   end

   // register reads, data valid in the cycle after the strobe only
   always_comb begin
      rdMux = '0;
      case (regAddr)
         A_CTRL:  rdMux[CTRL_W-1:0] = ctrl_q;
         A_RATE:  rdMux[11:0] = rate_q;
         A_CHAN: begin
            rdMux[CH_BUND_LSB +: 2]  = trunc_q ? BUND_ARB : bund_q;
            rdMux[CH_START_LSB +: 5] = start_q;
            rdMux[CH_COUNT_LSB +: 6] = count_q;
         end
         A_ASYNC: rdMux[6:0] = async_q;
         A_LEADS: rdMux[5:0] = leads_q;
         A_STAT: begin
            rdMux[S_DTR]  = dtrS2_q;
            rdMux[S_DSR]  = dsrOut_q;
            rdMux[S_RTS]  = rtsEff;
            rdMux[S_CTS]  = ctsOut_q;
            rdMux[S_DCD]  = dcdOut_q;
            rdMux[S_DTE]  = roleDte_q;
            rdMux[S_ALM]  = dtrAlarm_q;
            rdMux[S_EXT]  = useExt;
            rdMux[S_HOLD] = flowHold_q;
         end
         A_MAP:   rdMux = map_q;
         A_CHAR: begin
            rdMux[7:0]    = charData_q;
            rdMux[R_PERR] = perr_q;
            rdMux[R_FERR] = ferr_q;
         end
         default: rdMux = '0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) regRdata_q <= '0;
      else regRdata_q <= regRd ? rdMux : '0;
   end

   assign regRdata = regRdata_q;
   assign txClkOut = txClk_q;
   assign ctsOut   = ctsOut_q;
   assign dcdOut   = dcdOut_q;
   assign dsrOut   = dsrOut_q;
   assign dtrAlarm = dtrAlarm_q;
   assign bitData  = bitData_q;
   assign bitStb   = bitStb_q;
   assign charData = charData_q;
   assign charStb  = charStb_q;
   assign flowHold = flowHold_q;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);

   property p_ces_dce;
      ctrl_q[C_CES] |=> !roleDte_q;
   endproperty
   a_ces_dce: assert property (p_ces_dce) else $error("dte under ces");

   property p_rate_rng;
      rate_q >= RATE_MIN && rate_q <= RATE_MAX;
   endproperty
   a_rate_rng: assert property (p_rate_rng) else $error("rate out");

   property p_arb_ref;
      regWr && regAddr == A_CHAN && regWdata[CH_BUND_LSB +: 2] == BUND_ARB
         |=> bund_q == $past(bund_q);
   endproperty
   a_arb_ref: assert property (p_arb_ref) else $error("arb taken");

   property p_map_off;
      !ctrl_q[C_CES] && $past(!ctrl_q[C_CES]) |-> map_q == '0;
   endproperty
   a_map_off: assert property (p_map_off) else $error("map live");

   property p_ces_int;
      ctrl_q[C_CES] && sampleEv |-> ncoTick;
   endproperty
   a_ces_int: assert property (p_ces_int) else $error("ext clk");

   property p_alarm;
      ctrl_q[C_DTRALM] && !dtrS2_q ##1 ctrl_q[C_DTRALM] |-> dtrAlarm_q;
   endproperty
   a_alarm: assert property (p_alarm) else $error("no alarm");

   property p_cts_wait;
      $changed(ctsInt_q) |-> $past(ctsCnt_q) >= $past(ctsDly);
   endproperty
   a_cts_wait: assert property (p_cts_wait) else $error("cts early");

   property p_cts_false;
      leads_q[LD_CTS_LSB +: 2] == LEAD_FALSE ##1
         leads_q[LD_CTS_LSB +: 2] == LEAD_FALSE |-> !ctsOut_q;
   endproperty
   a_cts_false: assert property (p_cts_false) else $error("cts");

   property p_dsr_int;
      leads_q[LD_DSR_LSB +: 2] == LEAD_INT && ctrl_q[C_PORTEN] ##1
         leads_q[LD_DSR_LSB +: 2] == LEAD_INT |-> dsrOut_q;
   endproperty
   a_dsr_int: assert property (p_dsr_int) else $error("dsr");

   property p_xoff;
      asFlow == FLOW_XON && ctrl_q[C_ASYNC] && charStb_q &&
         charData_q == CHR_XOFF ##1 asFlow == FLOW_XON && ctrl_q[C_ASYNC]
         |=> flowHold_q;
   endproperty
   a_xoff: assert property (p_xoff) else $error("xoff lost");

   c_cts_chg: cover property ($changed(ctsInt_q));
   c_char:    cover property (charStb_q);
   c_alarm:   cover property ($rose(dtrAlarm_q));
   c_ext:     cover property (useExt && sampleEv);

endmodule // splfc_top

`default_nettype wire

// ### testbench/splfc_dte_model.sv
// attached terminal model: transmit data and its own clock
`timescale 1ns/1ns
`default_nettype none
module splfc_dte_model (
   input  wire logic txClk,
   output logic      extClk,
   output logic      txData
);
   initial begin
      extClk = 1'b0;
      txData = 1'b1;
   end
   // clock runs only in a frame; data moves mid-low so both edges are safe
   task automatic sendSync(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         txData = v[i];
         #20 extClk = 1'b1;
         #40 extClk = 1'b0;
         #20;
      end
      txData = ~v[7];
   endtask
   // async frame lsb first on the falling port clock; line rests at mark
   task automatic sendAsync(input logic [11:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge txClk);
         txData = b[i];
      end
   endtask
endmodule // splfc_dte_model
`default_nettype wire

// ### testbench/splfc_top_bench.sv
// bench: registers, leads, sync and async receive of the serial port
`timescale 1ns/1ns
`default_nettype none
module splfc_top_bench;
   import splfc_pkg::*;
   logic        mclk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [4:0]  regAddr = '0;
   logic [31:0] regWdata = '0, regRdata;
   logic        txClkOut, extClkIn, txDataIn, ctsOut, dcdOut, dsrOut;
   logic        dtrIn = 1'b1, rtsIn = 1'b0, carrierIn = 1'b0, rdPend = 1'b0;
   logic        dtrAlarm, bitData, bitStb, charStb, flowHold;
   logic [7:0]  charData, d;
   logic [31:0] rdQ[$], mskQ[$];
   logic        bitQ[$];
   logic [7:0]  chrQ[$];
   int          errors = 0, n_compared = 0, seed = 86;
   always #4 mclk = ~mclk;
   splfc_top #(.CtsNormCyc(24'h14), .CtsLongCyc(24'h32)) u_splfc_top (
      .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .txClkOut(txClkOut), .extClkIn(extClkIn), .txDataIn(txDataIn),
      .dtrIn(dtrIn), .rtsIn(rtsIn), .carrierIn(carrierIn), .ctsOut(ctsOut),
      .dcdOut(dcdOut), .dsrOut(dsrOut), .dtrAlarm(dtrAlarm),
      .bitData(bitData), .bitStb(bitStb), .charData(charData),
      .charStb(charStb), .flowHold(flowHold));
   splfc_dte_model u_splfc_dte_model (
      .txClk(txClkOut), .extClk(extClkIn), .txData(txDataIn));
   task automatic cmp(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   // strobes are lowered by the next access or by cyc, never twice a step
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      regRd    <= 1'b0;
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= v;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, m);
      regWr   <= 1'b0;
      regRd   <= 1'b1;
      regAddr <= a;
      rdQ.push_back(e);
      mskQ.push_back(m);
      @(posedge mclk);
   endtask
   task automatic cyc(input int n);
      regWr <= 1'b0;
      regRd <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   task automatic finish_test;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // results are taken off the queues as the design presents them
   always @(posedge mclk) begin
      rdPend <= regRd;
      if (rdPend)
         cmp("regRdata", rdQ.pop_front(), regRdata & mskQ.pop_front());
      if (bitStb === 1'b1)
         cmp("bitData", bitQ.size() ? 32'(bitQ.pop_front()) : 'x, 32'(bitData));
      if (charStb === 1'b1)
         cmp("charData", chrQ.size() ? 32'(chrQ.pop_front()) : 'x, 32'(charData));
   end
   initial begin
      #200000;
      errors++;
      finish_test();
   end
   initial begin
      cyc(6);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(A_CTRL, 32'h40, '1);
      rd(A_CHAN, 32'h10, '1);
      rd(A_ASYNC, 32'hc, '1);
      rd(A_LEADS, 32'h0, '1);
      rd(5'h1e, 32'h0, '1);
      wr(A_CTRL, 32'h48);
      wr(A_RATE, 32'h3f);
      wr(A_RATE, 32'h901);
      rd(A_RATE, 32'h800, '1);
      wr(A_RATE, 32'h900);
      rd(A_RATE, 32'h900, '1);
      for (int k = 0; k < 2; k++) begin
         wr(A_CTRL, k ? 32'h58 : 32'h48);
         cyc(1);
         d = 8'($random(seed));
         d[7] = k == 0; // line rests at mark after the last frame
         for (int i = 0; i < 8; i++) bitQ.push_back(d[i]);
         u_splfc_dte_model.sendSync(d);
         cyc(8);
      end
      cmp("bitQ", 0, bitQ.size());
      wr(A_CTRL, 32'h0b);
      rd(A_STAT, 32'h0, 32'ha0);
      wr(A_CHAN, 32'h2);
      rd(A_CHAN, 32'h10, '1);
      wr(A_CHAN, 32'h30051);
      cyc(1);
      rd(A_MAP, 32'h2a0, '1);
      wr(A_CHAN, 32'h190000);
      rd(A_CHAN, 32'h30050, '1);
      rd(A_MAP, 32'he0, '1);
      wr(A_CTRL, 32'h20b);
      wr(A_CHAN, 32'h200000);
      cyc(1);
      rd(A_MAP, 32'hffffffff, '1);
      wr(A_CHAN, 32'h200001);
      cyc(1);
      rd(A_CHAN, 32'h200002, '1);
      rd(A_MAP, 32'h55555555, '1);
      wr(A_CTRL, 32'h64);
      for (int k = 0; k < 4; k++) begin
         wr(A_ASYNC, k == 0 ? 32'h2c : k == 1 ? 32'h50 : 32'h0d);
         cyc(1);
         d = k == 2 ? CHR_XOFF : k == 3 ? CHR_XON : 8'($random(seed));
         if (k == 1) d[7:5] = 3'h0;
         chrQ.push_back(d);
         if (k == 1) u_splfc_dte_model.sendAsync({2'h3, ~^d, d[4:0], 1'b0}, 9);
         else u_splfc_dte_model.sendAsync({1'b1, k ? 1'b1 : ^d, d, 1'b0}, 11);
         cyc(40);
         if (k > 1) cmp("flowHold", 32'(k == 2), 32'(flowHold));
      end
      dtrIn <= 1'b0;
      cyc(6);
      cmp("dtrAlarm", 1, 32'(dtrAlarm));
      rd(A_STAT, 32'h40, 32'h40);
      dtrIn <= 1'b1;
      carrierIn <= 1'b1;
      wr(A_LEADS, 32'h1a);
      cyc(40);
      cmp("dtrAlarm", 0, 32'(dtrAlarm));
      cmp("ctsOut", 0, 32'(ctsOut));
      cmp("dcdOut", 1, 32'(dcdOut));
      cmp("dsrOut", 0, 32'(dsrOut));
      rtsIn <= 1'b1;
      cyc(10);
      rtsIn <= 1'b0;
      cyc(40);
      cmp("ctsOut", 0, 32'(ctsOut));
      rtsIn <= 1'b1;
      cyc(15);
      cmp("ctsOut", 0, 32'(ctsOut));
      cyc(15);
      cmp("ctsOut", 1, 32'(ctsOut));
      wr(A_CTRL, 32'h164);
      rtsIn <= 1'b0;
      cyc(40);
      cmp("ctsOut", 1, 32'(ctsOut));
      cyc(20);
      cmp("ctsOut", 0, 32'(ctsOut));
      wr(A_LEADS, 32'h2a);
      carrierIn <= 1'b0;
      cyc(4);
      cmp("dcdOut", 0, 32'(dcdOut));
      cmp("dsrOut", 1, 32'(dsrOut));
      wr(A_CTRL, 32'he5);
      cyc(1);
      rd(A_STAT, 32'h24, 32'h24);
      cyc(24);
      cmp("ctsOut", 1, 32'(ctsOut));
      carrierIn <= 1'b1;
      wr(A_LEADS, 32'h05);
      cyc(2);
      cmp("ctsOut", 0, 32'(ctsOut));
      cmp("dcdOut", 0, 32'(dcdOut));
      cmp("dsrOut", 1, 32'(dsrOut));
      finish_test();
   end
endmodule // splfc_top_bench
`default_nettype wire
